// *** rtcr_defines.svh ***
// register offsets, field positions and reset values of the calendar clock
// assumes a 32-bit apb slave with 8-bit byte addresses
//
// Overview of operation
// - date setup word holds year 23:12, month 11:8, day 4:0, reset zero
// - time setup word holds weekday 26:24 (sunday 0), hours, minutes, seconds
// - leap override bit 8 of control forces the current year to be non-leap
// - alarm compares only enabled fields and matches when all of them agree
// - masked status is raw alarm bit and enable, or force; raw resets zero
// - reading current time captures current date into a holding register
// - one-second tick is the reference clock divided by divider plus one
// - with few match enables the alarm recurs at every new match
`ifndef RTCR_DEFINES_SVH
`define RTCR_DEFINES_SVH

`define RTCR_OFF_DIV     8'h00
`define RTCR_OFF_DSET    8'h04
`define RTCR_OFF_TSET    8'h08
`define RTCR_OFF_CTRL    8'h0c
`define RTCR_OFF_ADSET   8'h10
`define RTCR_OFF_ATSET   8'h14
`define RTCR_OFF_CDATE   8'h18
`define RTCR_OFF_CTIME   8'h1c
`define RTCR_OFF_IRAW    8'h20
`define RTCR_OFF_IEN     8'h24
`define RTCR_OFF_IFRC    8'h28
`define RTCR_OFF_ISTS    8'h2c

`define RTCR_MASK_DATE   32'h00ff_ff1f
`define RTCR_MASK_TIME   32'h071f_3f3f
`define RTCR_MASK_ADATE  32'h17ff_ff1f
`define RTCR_MASK_ATIME  32'hf71f_3f3f
`define RTCR_RST_WORD    32'h0000_0000
`define RTCR_RST_DIV     16'h0000

`define RTCR_YEAR        23:12
`define RTCR_MONTH       11:8
`define RTCR_DAY         4:0
`define RTCR_WDAY        26:24
`define RTCR_HOUR        20:16
`define RTCR_MIN         13:8
`define RTCR_SEC         5:0

`define RTCR_CTRL_EN     0
`define RTCR_CTRL_ACT    1
`define RTCR_CTRL_LOAD   4
`define RTCR_CTRL_LEAP   8
`define RTCR_A_YEAR_ON   26
`define RTCR_A_MONTH_ON  25
`define RTCR_A_DAY_ON    24
`define RTCR_A_GLOBAL    28
`define RTCR_A_ARMED     29
`define RTCR_A_WDAY_ON   31
`define RTCR_A_HOUR_ON   30
`define RTCR_A_MIN_ON    29
`define RTCR_A_SEC_ON    28

`endif

// *** rtcr_pkg.sv ***
// types shared by the calendar clock files
// assumes nothing beyond the defines header
`default_nettype none
package rtcr_pkg;
  typedef logic [11:0] rtcr_year_t;
  typedef logic [3:0]  rtcr_month_t;
  typedef logic [4:0]  rtcr_day_t;
  typedef logic [2:0]  rtcr_wday_t;
  typedef logic [4:0]  rtcr_hour_t;
  typedef logic [5:0]  rtcr_minsec_t;
endpackage
`default_nettype wire

// *** rtcr_calendar.sv ***
// running calendar counters, advanced by a one-second tick
// assumes tick and load are single-cycle pulses on clk_sys
`timescale 1ns/1ns
`default_nettype none
module rtcr_calendar
  import rtcr_pkg::*;
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  // control
  input  wire logic   tick,
  input  wire logic   load,
  input  wire logic   leap_override,
  // preset values
  input  wire rtcr_year_t   set_year,
  input  wire rtcr_month_t  set_month,
  input  wire rtcr_day_t    set_day,
  input  wire rtcr_wday_t   set_wday,
  input  wire rtcr_hour_t   set_hour,
  input  wire rtcr_minsec_t set_min,
  input  wire rtcr_minsec_t set_sec,
  // running values
  output var rtcr_year_t   year,
  output var rtcr_month_t  month,
  output var rtcr_day_t    day,
  output var rtcr_wday_t   wday,
  output var rtcr_hour_t   hour,
  output var rtcr_minsec_t min,
  output var rtcr_minsec_t sec
);
  logic      is_leap;
  rtcr_day_t dim;

  // century years that are not leap are left to software via the override
  assign is_leap = (year[1:0] == 2'h0) && !leap_override;

  always_comb begin
    unique case (month)
      4'h2:                      dim = is_leap ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb:    dim = 5'h1e;
      default:                   dim = 5'h1f;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      year  <= 12'h000;
      month <= 4'h0;
      day   <= 5'h00;
      wday  <= 3'h0;
      hour  <= 5'h00;
      min   <= 6'h00;
      sec   <= 6'h00;
    end else if (load) begin
      year  <= set_year;
      month <= set_month;
      day   <= set_day;
      wday  <= set_wday;
      hour  <= set_hour;
      min   <= set_min;
      sec   <= set_sec;
    end else if (tick) begin
      sec <= (sec == 6'h3b) ? 6'h00 : sec + 6'h01;
      if (sec == 6'h3b) begin
        min <= (min == 6'h3b) ? 6'h00 : min + 6'h01;
        if (min == 6'h3b) begin
          hour <= (hour == 5'h17) ? 5'h00 : hour + 5'h01;
          if (hour == 5'h17) begin
            wday <= (wday == 3'h6) ? 3'h0 : wday + 3'h1;
            day  <= (day >= dim) ? 5'h01 : day + 5'h01;
            if (day >= dim) begin
              month <= (month >= 4'hc) ? 4'h1 : month + 4'h1;
              if (month >= 4'hc) begin
                year <= year + 12'h001;
              end
            end
          end
        end
      end
    end
  end
endmodule // rtcr_calendar
`default_nettype wire

// *** rtcr_top.sv ***
// calendar clock register block: apb slave, tick divider, alarm, interrupt
// assumes apb signals come from logic on clk_sys; arst_n may be asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "rtcr_defines.svh"
module rtcr_top
  import rtcr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // interrupt
  output var  logic        irq
);
  logic         rst_meta_r;
  logic         rst_sync_r;
  logic         rst_n;
  logic         pready_r;
  logic         pslverr_r;
  logic [31:0]  prdata_r;
  logic [31:0]  rdata_nxt;
  logic         hit_nxt;
  logic         wr;
  logic         rd;
  logic [15:0]  div_r;
  logic [15:0]  cnt_r;
  logic         tick;
  logic [31:0]  dset_r;
  logic [31:0]  tset_r;
  logic [31:0]  adset_r;
  logic [31:0]  atset_r;
  logic         en_r;
  logic         active_r;
  logic         leap_r;
  logic         load_r;
  logic         armed_r;
  logic         match_r;
  logic         alarm_hit;
  logic         alarm_evt;
  logic         raw_r;
  logic         ien_r;
  logic         ifrc_r;
  logic         ists;
  logic         irq_r;
  logic [31:0]  cur_date;
  logic [31:0]  cur_time;
  logic [31:0]  hold_r;
  rtcr_year_t   c_year;
  rtcr_month_t  c_month;
  rtcr_day_t    c_day;
  rtcr_wday_t   c_wday;
  rtcr_hour_t   c_hour;
  rtcr_minsec_t c_min;
  rtcr_minsec_t c_sec;

  // reset release through two flops; assertion is still immediate
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // apb: one wait-free access phase, read data prepared in the setup cycle
  assign wr = psel && penable && pready_r && pwrite;
  assign rd = psel && penable && pready_r && !pwrite;

  assign cur_date = {8'h00, c_year, c_month, 3'h0, c_day};
  assign cur_time = {5'h00, c_wday, 3'h0, c_hour, 2'h0, c_min, 2'h0, c_sec};
  assign ists     = (raw_r && ien_r) || ifrc_r;

  always_comb begin
    rdata_nxt = `RTCR_RST_WORD;
    hit_nxt   = 1'b1;
    unique case (paddr)
      `RTCR_OFF_DIV:   rdata_nxt = {16'h0000, div_r};
      `RTCR_OFF_DSET:  rdata_nxt = dset_r;
      `RTCR_OFF_TSET:  rdata_nxt = tset_r;
      `RTCR_OFF_CTRL:  rdata_nxt = {23'h00_0000, leap_r, 6'h00, active_r, en_r};
      `RTCR_OFF_ADSET: rdata_nxt = adset_r | {2'h0, armed_r, 29'h0000_0000};
      `RTCR_OFF_ATSET: rdata_nxt = atset_r;
      `RTCR_OFF_CDATE: rdata_nxt = hold_r;
      `RTCR_OFF_CTIME: rdata_nxt = cur_time;
      `RTCR_OFF_IRAW:  rdata_nxt = {31'h0000_0000, raw_r};
      `RTCR_OFF_IEN:   rdata_nxt = {31'h0000_0000, ien_r};
      `RTCR_OFF_IFRC:  rdata_nxt = {31'h0000_0000, ifrc_r};
      `RTCR_OFF_ISTS:  rdata_nxt = {31'h0000_0000, ists};
      default:         hit_nxt   = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `RTCR_RST_WORD;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !hit_nxt;
      if (psel && !penable) begin
        prdata_r <= pwrite ? `RTCR_RST_WORD : rdata_nxt;
      end
    end
  end

  // setup and alarm words; reserved bits are never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r   <= `RTCR_RST_DIV;
      dset_r  <= `RTCR_RST_WORD;
      tset_r  <= `RTCR_RST_WORD;
      adset_r <= `RTCR_RST_WORD;
      atset_r <= `RTCR_RST_WORD;
    end else if (wr) begin
      if (paddr == `RTCR_OFF_DIV)   div_r   <= pwdata[15:0];
      if (paddr == `RTCR_OFF_DSET)  dset_r  <= pwdata & `RTCR_MASK_DATE;
      if (paddr == `RTCR_OFF_TSET)  tset_r  <= pwdata & `RTCR_MASK_TIME;
      // alarm words are taken as written; the comparator trusts software
      // to drop the global enable before touching them
      if (paddr == `RTCR_OFF_ADSET) adset_r <= pwdata & `RTCR_MASK_ADATE;
      if (paddr == `RTCR_OFF_ATSET) atset_r <= pwdata & `RTCR_MASK_ATIME;
    end
  end

  // control: enable and leap are plain, load pulses for one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_r     <= 1'b0;
      leap_r   <= 1'b0;
      load_r   <= 1'b0;
      active_r <= 1'b0;
    end else begin
      load_r   <= wr && (paddr == `RTCR_OFF_CTRL) && pwdata[`RTCR_CTRL_LOAD];
      active_r <= en_r;
      if (wr && (paddr == `RTCR_OFF_CTRL)) begin
        en_r   <= pwdata[`RTCR_CTRL_EN];
        leap_r <= pwdata[`RTCR_CTRL_LEAP];
      end
    end
  end

  // second divider; a divider changed while running takes effect mid-count
  assign tick = active_r && !load_r && (cnt_r >= div_r);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
    end else if (!active_r || load_r || tick) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  rtcr_calendar u_cal (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .tick          (tick),
    .load          (load_r),
    .leap_override (leap_r),
    .set_year      (dset_r[`RTCR_YEAR]),
    .set_month     (dset_r[`RTCR_MONTH]),
    .set_day       (dset_r[`RTCR_DAY]),
    .set_wday      (tset_r[`RTCR_WDAY]),
    .set_hour      (tset_r[`RTCR_HOUR]),
    .set_min       (tset_r[`RTCR_MIN]),
    .set_sec       (tset_r[`RTCR_SEC]),
    .year          (c_year),
    .month         (c_month),
    .day           (c_day),
    .wday          (c_wday),
    .hour          (c_hour),
    .min           (c_min),
    .sec           (c_sec)
  );

  // date hold keeps a two-word read coherent across a midnight roll
  // caught at the setup edge, the same edge that snapshots the time word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= `RTCR_RST_WORD;
    end else if (psel && !penable && !pwrite && (paddr == `RTCR_OFF_CTIME)) begin
      hold_r <= cur_date;
    end
  end

  // alarm comparator over the enabled fields only
  always_comb begin
    alarm_hit = adset_r[`RTCR_A_GLOBAL];
    if (adset_r[`RTCR_A_YEAR_ON] && (adset_r[`RTCR_YEAR] != c_year)) alarm_hit = 1'b0;
    if (adset_r[`RTCR_A_MONTH_ON] && (adset_r[`RTCR_MONTH] != c_month)) alarm_hit = 1'b0;
    if (adset_r[`RTCR_A_DAY_ON] && (adset_r[`RTCR_DAY] != c_day)) alarm_hit = 1'b0;
    if (atset_r[`RTCR_A_WDAY_ON] && (atset_r[`RTCR_WDAY] != c_wday)) alarm_hit = 1'b0;
    if (atset_r[`RTCR_A_HOUR_ON] && (atset_r[`RTCR_HOUR] != c_hour)) alarm_hit = 1'b0;
    if (atset_r[`RTCR_A_MIN_ON] && (atset_r[`RTCR_MIN] != c_min)) alarm_hit = 1'b0;
    if (atset_r[`RTCR_A_SEC_ON] && (atset_r[`RTCR_SEC] != c_sec)) alarm_hit = 1'b0;
    if (!active_r) alarm_hit = 1'b0;
  end

  // an event is the start of a match, so partial enables recur
  assign alarm_evt = alarm_hit && !match_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      match_r <= alarm_hit;
      armed_r <= adset_r[`RTCR_A_GLOBAL] && active_r;
    end
  end

  // interrupt: sticky raw bit, write one to clear, a new event wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raw_r <= 1'b0;
    end else if (alarm_evt) begin
      raw_r <= 1'b1;
    end else if (wr && (paddr == `RTCR_OFF_IRAW) && pwdata[0]) begin
      raw_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ien_r  <= 1'b0;
      ifrc_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      irq_r <= ists;
      if (wr && (paddr == `RTCR_OFF_IEN))  ien_r  <= pwdata[0];
      if (wr && (paddr == `RTCR_OFF_IFRC)) ifrc_r <= pwdata[0];
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_load_req;
    wr && (paddr == `RTCR_OFF_CTRL) && pwdata[`RTCR_CTRL_LOAD];
  endsequence
  property p_load_copy;
    s_load_req ##1 load_r |=> (c_sec == tset_r[`RTCR_SEC]) && (c_year == dset_r[`RTCR_YEAR]);
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("load did not copy setup");

  property p_run_follow;
    $rose(en_r) |=> active_r;
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("running bit late");

  property p_irq_level;
    ##1 irq == $past(ists);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not masked status");

  property p_raw_set;
    alarm_evt |=> raw_r && !alarm_evt;
  endproperty
  a_raw_set: assert property (p_raw_set) else $error("alarm event lost");

  property p_hold;
    psel && !penable && !pwrite && (paddr == `RTCR_OFF_CTIME) |=>
      (hold_r == $past(cur_date)) && (prdata == $past(cur_time));
  endproperty
  a_hold: assert property (p_hold) else $error("date not captured on time read");

  property p_tick_gap;
    tick && (div_r != 16'h0000) && !wr |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

  property p_sec_match;
    alarm_evt |-> adset_r[`RTCR_A_GLOBAL] && (!atset_r[`RTCR_A_SEC_ON] || (c_sec == atset_r[`RTCR_SEC]));
  endproperty
  a_sec_match: assert property (p_sec_match) else $error("alarm on mismatch");

  property p_dset_wr;
    wr && (paddr == `RTCR_OFF_DSET) |=> dset_r == ($past(pwdata) & `RTCR_MASK_DATE);
  endproperty
  a_dset_wr: assert property (p_dset_wr) else $error("date setup write lost");

  property p_tset_wr;
    wr && (paddr == `RTCR_OFF_TSET) |=> tset_r[`RTCR_WDAY] == $past(pwdata[26:24]);
  endproperty
  a_tset_wr: assert property (p_tset_wr) else $error("time setup write lost");

  property p_hold_read;
    psel && !penable && !pwrite && (paddr == `RTCR_OFF_CDATE) |=> prdata == $past(hold_r);
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("date read not from hold");

  property p_raw_clear;
    wr && (paddr == `RTCR_OFF_IRAW) && pwdata[0] && !alarm_evt |=> !raw_r;
  endproperty
  a_raw_clear: assert property (p_raw_clear) else $error("raw bit not cleared");

  property p_date_match;
    alarm_evt |-> (!adset_r[`RTCR_A_YEAR_ON] || (c_year == adset_r[`RTCR_YEAR])) &&
                  (!adset_r[`RTCR_A_MONTH_ON] || (c_month == adset_r[`RTCR_MONTH])) &&
                  (!adset_r[`RTCR_A_DAY_ON] || (c_day == adset_r[`RTCR_DAY]));
  endproperty
  a_date_match: assert property (p_date_match) else $error("alarm on date mismatch");

  property p_time_match;
    alarm_evt |-> (!atset_r[`RTCR_A_WDAY_ON] || (c_wday == atset_r[`RTCR_WDAY])) &&
                  (!atset_r[`RTCR_A_HOUR_ON] || (c_hour == atset_r[`RTCR_HOUR])) &&
                  (!atset_r[`RTCR_A_MIN_ON] || (c_min == atset_r[`RTCR_MIN]));
  endproperty
  a_time_match: assert property (p_time_match) else $error("alarm on time mismatch");

  // the last tick of february 28 is where the leap choice shows
  sequence s_feb28_end;
    tick && (c_month == 4'h2) && (c_day == 5'h1c) &&
    (c_hour == 5'h17) && (c_min == 6'h3b) && (c_sec == 6'h3b);
  endsequence
  property p_leap_skip;
    s_feb28_end ##0 leap_r |=> (c_month == 4'h3) && (c_day == 5'h01);
  endproperty
  a_leap_skip: assert property (p_leap_skip) else $error("override kept february 29");

  property p_leap_keep;
    s_feb28_end ##0 (!leap_r && (c_year[1:0] == 2'h0)) |=> (c_month == 4'h2) && (c_day == 5'h1d);
  endproperty
  a_leap_keep: assert property (p_leap_keep) else $error("leap day skipped");

  property p_load_pulse;
    load_r |=> !load_r;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load bit not self clearing");
endmodule // rtcr_top
`default_nettype wire

// *** tb_calendar_clock_regs.sv ***
// self-checking bench of the calendar clock register block
// assumes rtcr_top alone on a 50 MHz clk_sys, this bench as its only apb master
`timescale 1ns/1ns
`default_nettype none
`include "rtcr_defines.svh"
module tb_calendar_clock_regs;
  import rtcr_pkg::*;
  logic             clk_sys = 1'b0;
  logic             arst_n  = 1'b0;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic [7:0]       paddr   = 8'h00;
  logic [31:0]      pwdata  = 32'h0000_0000;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        irq;
  int               bad_count = 0;
  int               checks_done = 0;
  logic [31:0]      q;
  logic             e;

  always #10 clk_sys = ~clk_sys;

  rtcr_top dut (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq)
  );

  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic stuck();
    bad_count++;
    $display("[FAIL] %0t: wait ran out", $time);
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // request held from setup until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) stuck();
      @(posedge clk_sys);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  function automatic logic [31:0] tw(input logic [2:0] wd, input logic [4:0] h, input logic [5:0] m,
                                     input logic [5:0] s);
    return {5'h00, wd, 3'h0, h, 2'h0, m, 2'h0, s};
  endfunction

  function automatic logic [31:0] dw(input logic [11:0] y, input logic [3:0] mo, input logic [4:0] d);
    return {8'h00, y, mo, 3'h0, d};
  endfunction

  task automatic t_reset();
    for (int i = 0; i < 12; i++) begin
      rd(8'(4 * i), 32'h0000_0000);
    end
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    wr(8'h30, 32'hffff_ffff);
    chk({31'h0, e}, 32'h0000_0001);
  endtask

  // all ones show which bits exist; read-only words must ignore writes
  task automatic t_fields();
    wr(`RTCR_OFF_DSET, 32'hffff_ffff);
    rd(`RTCR_OFF_DSET, `RTCR_MASK_DATE);
    wr(`RTCR_OFF_TSET, 32'hffff_ffff);
    rd(`RTCR_OFF_TSET, `RTCR_MASK_TIME);
    wr(`RTCR_OFF_ATSET, 32'hffff_ffff);
    rd(`RTCR_OFF_ATSET, `RTCR_MASK_ATIME);
    wr(`RTCR_OFF_ADSET, 32'hffff_ffff);
    rd(`RTCR_OFF_ADSET, `RTCR_MASK_ADATE);
    wr(`RTCR_OFF_ADSET, 32'h0000_0000);
    wr(`RTCR_OFF_ATSET, 32'h0000_0000);
    wr(`RTCR_OFF_CTIME, 32'hffff_ffff);
    wr(`RTCR_OFF_CDATE, 32'hffff_ffff);
    wr(`RTCR_OFF_IRAW, 32'hffff_ffff);
    wr(`RTCR_OFF_ISTS, 32'hffff_ffff);
    rd(`RTCR_OFF_CTIME, 32'h0000_0000);
    rd(`RTCR_OFF_CDATE, 32'h0000_0000);
    rd(`RTCR_OFF_ISTS, 32'h0000_0000);
  endtask

  // saturday feb 28 23:59:59 rolls over on the first tick
  task automatic t_cal(input logic [11:0] y, input logic lo, input logic [3:0] mo, input logic [4:0] d);
    int n;
    n = 0;
    wr(`RTCR_OFF_CTRL, 32'h0000_0000);
    wr(`RTCR_OFF_DSET, dw(y, 4'h2, 5'h1c));
    wr(`RTCR_OFF_TSET, tw(3'h6, 5'h17, 6'h3b, 6'h3b));
    wr(`RTCR_OFF_CTRL, {23'h0, lo, 8'h11});
    rd(`RTCR_OFF_CTIME, tw(3'h6, 5'h17, 6'h3b, 6'h3b));
    rd(`RTCR_OFF_CTRL, {23'h0, lo, 8'h03});
    while (q === tw(3'h6, 5'h17, 6'h3b, 6'h3b) || q === {23'h0, lo, 8'h03}) begin
      n++;
      if (n > 50) stuck();
      apb(1'b0, `RTCR_OFF_CTIME, 32'h0000_0000);
    end
    chk(q, tw(3'h0, 5'h00, 6'h00, 6'h00));
    rd(`RTCR_OFF_CDATE, dw(y, mo, d));
  endtask

  task automatic t_alarm();
    int n;
    n = 0;
    wr(`RTCR_OFF_CTRL, 32'h0000_0000);
    wr(`RTCR_OFF_ADSET, 32'h0000_0000);
    wr(`RTCR_OFF_TSET, tw(3'h0, 5'h00, 6'h00, 6'h32));
    wr(`RTCR_OFF_ATSET, 32'h1000_0036);
    wr(`RTCR_OFF_IEN, 32'h0000_0001);
    wr(`RTCR_OFF_CTRL, 32'h0000_0011);
    wr(`RTCR_OFF_ADSET, 32'h1000_0000);
    rd(`RTCR_OFF_ADSET, 32'h3000_0000);
    while (irq !== 1'b1) begin
      n++;
      if (n > 400) stuck();
      @(posedge clk_sys);
    end
    rd(`RTCR_OFF_CTIME, tw(3'h0, 5'h00, 6'h00, 6'h36));
    rd(`RTCR_OFF_IRAW, 32'h0000_0001);
    rd(`RTCR_OFF_ISTS, 32'h0000_0001);
    wr(`RTCR_OFF_IEN, 32'h0000_0000);
    wr(`RTCR_OFF_IRAW, 32'h0000_0001);
    rd(`RTCR_OFF_ISTS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // masked recurrence a minute later still sets the raw bit
    n = 0;
    q = 32'h0000_0000;
    while (q !== 32'h0000_0001) begin
      n++;
      if (n > 500) stuck();
      apb(1'b0, `RTCR_OFF_IRAW, 32'h0000_0000);
    end
    rd(`RTCR_OFF_CTIME, tw(3'h0, 5'h00, 6'h01, 6'h36));
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`RTCR_OFF_IFRC, 32'h0000_0001);
    rd(`RTCR_OFF_IFRC, 32'h0000_0001);
    rd(`RTCR_OFF_ISTS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`RTCR_OFF_IFRC, 32'h0000_0000);
    wr(`RTCR_OFF_IEN, 32'h0000_0001);
    rd(`RTCR_OFF_ISTS, 32'h0000_0001);
    wr(`RTCR_OFF_IRAW, 32'h0000_0001);
    rd(`RTCR_OFF_IRAW, 32'h0000_0000);
    rd(`RTCR_OFF_ISTS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // date, weekday and hour enables: a full match fires at once, one wrong field never
  task automatic t_match();
    wr(`RTCR_OFF_ADSET, 32'h0000_0000);
    wr(`RTCR_OFF_IRAW, 32'h0000_0001);
    wr(`RTCR_OFF_ATSET, 32'hc000_0000);
    wr(`RTCR_OFF_ADSET, 32'h177e_821c);
    rd(`RTCR_OFF_IRAW, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`RTCR_OFF_ADSET, 32'h0000_0000);
    wr(`RTCR_OFF_IRAW, 32'h0000_0001);
    wr(`RTCR_OFF_ADSET, 32'h177e_831c);
    rd(`RTCR_OFF_IRAW, 32'h0000_0000);
    wr(`RTCR_OFF_ADSET, 32'h0000_0000);
    wr(`RTCR_OFF_ATSET, 32'h4005_0000);
    wr(`RTCR_OFF_ADSET, 32'h1000_0000);
    rd(`RTCR_OFF_IRAW, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_fields();
    // short divider keeps a second at sixteen clocks
    wr(`RTCR_OFF_DIV, 32'h0000_000f);
    rd(`RTCR_OFF_DIV, 32'h0000_000f);
    t_cal(12'h834, 1'b1, 4'h3, 5'h01);
    t_cal(12'h7e8, 1'b0, 4'h2, 5'h1d);
    t_alarm();
    t_match();
    give_verdict();
  end
endmodule // tb_calendar_clock_regs
`default_nettype wire
